// File: rtl/crtcl_pkg.sv
// crtcl_pkg: constants shared by the crtc write-lock block
// assumes: indexed host i/o port bus, 8-bit data
package crtcl_pkg;

  // i/o port addresses
  localparam logic [15:0] CRTCL_PORT_IDX_MONO  = 16'h03B4;
  localparam logic [15:0] CRTCL_PORT_DAT_MONO  = 16'h03B5;
  localparam logic [15:0] CRTCL_PORT_IDX_COLOR = 16'h03D4;
  localparam logic [15:0] CRTCL_PORT_DAT_COLOR = 16'h03D5;
  localparam logic [15:0] CRTCL_PORT_MISC_WR   = 16'h03C2;
  localparam logic [15:0] CRTCL_PORT_MISC_RD   = 16'h03CC;
  localparam logic [15:0] CRTCL_PORT_GFX_IDX   = 16'h03CE;
  localparam logic [15:0] CRTCL_PORT_GFX_DAT   = 16'h03CF;

  // extended graphics index of the lock-control register
  localparam logic [7:0] CRTCL_GFX_LOCK_CTRL = 8'h0D;

  // crtc register count and indices
  localparam int         CRTCL_NREGS         = 25;
  localparam logic [4:0] CRTCL_IDX_HLAST     = 5'h05;
  localparam logic [4:0] CRTCL_IDX_VTOTAL    = 5'h06;
  localparam logic [4:0] CRTCL_IDX_OVERFLOW  = 5'h07;
  localparam logic [4:0] CRTCL_IDX_PRESET    = 5'h08;
  localparam logic [4:0] CRTCL_IDX_MAXSCAN   = 5'h09;
  localparam logic [4:0] CRTCL_IDX_CUR_START = 5'h0A;
  localparam logic [4:0] CRTCL_IDX_CUR_END   = 5'h0B;
  localparam logic [4:0] CRTCL_IDX_SA_HI     = 5'h0C;
  localparam logic [4:0] CRTCL_IDX_SA_LO     = 5'h0D;
  localparam logic [4:0] CRTCL_IDX_CUR_HI    = 5'h0E;
  localparam logic [4:0] CRTCL_IDX_CUR_LO    = 5'h0F;
  localparam logic [4:0] CRTCL_IDX_VRS       = 5'h10;
  localparam logic [4:0] CRTCL_IDX_VRE       = 5'h11;
  localparam logic [4:0] CRTCL_IDX_VBS       = 5'h15;
  localparam logic [4:0] CRTCL_IDX_VBE       = 5'h16;
  localparam logic [4:0] CRTCL_IDX_MODE      = 5'h17;

  // field positions
  localparam int CRTCL_VRE_PROTECT_BIT = 7;
  localparam int CRTCL_LC_VPOL_LOCK    = 7;
  localparam int CRTCL_LC_HPOL_LOCK    = 6;
  localparam int CRTCL_LC_HLOCK        = 5;
  localparam int CRTCL_LC_ADDR9        = 4;
  localparam int CRTCL_LC_ADDR8        = 3;
  localparam int CRTCL_LC_DOUBLE       = 2;
  localparam int CRTCL_LC_G1_PREVENT   = 1;
  localparam int CRTCL_LC_VLOCK        = 0;
  localparam int CRTCL_MISC_VPOL       = 7;
  localparam int CRTCL_MISC_HPOL       = 6;
  localparam int CRTCL_MISC_COLOR      = 0;

  // bit groups inside single registers
  localparam logic [7:0] CRTCL_OVF_G1_BITS   = 8'h42;
  localparam logic [7:0] CRTCL_OVF_G2_BITS   = 8'hAD;
  localparam logic [7:0] CRTCL_OVF_PROT_BITS = 8'h10;
  localparam logic [7:0] CRTCL_MAXSCAN_G3    = 8'h20;
  localparam logic [7:0] CRTCL_VRE_G3        = 8'h0F;
  localparam logic [7:0] CRTCL_MODE_G4       = 8'h04;

  // reset values
  localparam logic [7:0] CRTCL_RST_LOCK_CTRL = 8'h00;
  localparam logic [7:0] CRTCL_RST_MISC      = 8'h00;
  localparam logic [7:0] CRTCL_RST_CRTC      = 8'h00;
  localparam logic [7:0] CRTCL_RST_INDEX     = 8'h00;
  localparam logic [7:0] CRTCL_RD_NONE       = 8'h00;

endpackage

// File: rtl/crtcl_regs_if.sv
// crtcl_regs_if: write port and contents of the crtc register store
// assumes: single clock, writes already masked by the lock logic
`timescale 1ns/100ps
interface crtcl_regs_if #(
  parameter int N = 25
);
  logic                  we;
  logic [4:0]            idx;
  logic [7:0]            wdata;
  logic [7:0]            wmask;
  logic [N-1:0][7:0]     regs;

  modport ctrl  (output we, idx, wdata, wmask, input regs);
  modport store (input we, idx, wdata, wmask, output regs);
endinterface

// File: rtl/crtcl_regfile.sv
// crtcl_regfile: crtc register store with per-bit write mask
// assumes: masked bits keep their stored value
`timescale 1ns/100ps
module crtcl_regfile
  import crtcl_pkg::*;
#(
  parameter int N = 25
)(
  input  wire logic clk,
  input  wire logic nrst,
  crtcl_regs_if.store rf
);

  logic [N-1:0][7:0] regs_q;
  logic [N-1:0][7:0] regs_d;

  always_comb
  begin
    regs_d = regs_q;
    if (rf.we && (int'(rf.idx) < N))
    begin
      regs_d[rf.idx] = (regs_q[rf.idx] & ~rf.wmask)
                     | (rf.wdata & rf.wmask);  // [RULE12]
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regs_q <= '{default: CRTCL_RST_CRTC};
    else
      regs_q <= regs_d;
  end

  assign rf.regs = regs_q;

endmodule // crtcl_regfile

// File: rtl/crtcl_lock.sv
// crtcl_lock: crtc register write lock, lock-control register, host ports
// assumes: host i/o strobes synchronous to clk, one cycle each
//
// What this block does
// [RULE1] protect bit blocks writes to crtc 0-7, except overflow bits 6,1 when prevent is set
// [RULE2] horizontal lock or protect locks 00-05
// [RULE3] overflow bits 6,1 locked: no prevent, protect
// [RULE4] vertical lock or protect locks 06, overflow bits
// [RULE5] vertical lock locks 09.5,10,11[3:0],15,16
// [RULE6] horizontal lock locks mode bit 2
// [RULE7] lock-control at extended index 0D, read/write
// [RULE8] index port selects, data port accesses register
// [RULE9] doubling bit doubles cursor and scan values
// [RULE10] lock-control bit is address bit 8
// [RULE11] lock-control bit is address bit 9
// [RULE12] locked writes dropped, reads still return contents
// [RULE13] polarity lock bits block misc polarity writes
`timescale 1ns/100ps
module crtcl_lock
  import crtcl_pkg::*;
#(
  parameter int N = CRTCL_NREGS
)(
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic [15:0]     io_addr,
  input  wire logic            io_wr,
  input  wire logic            io_rd,
  input  wire logic [7:0]      io_wdata,
  output logic      [7:0]      io_rdata,
  output logic                 io_rvalid,
  output logic      [7:0]      lock_ctrl,
  output logic      [7:0]      misc_out,
  output logic      [8*N-1:0]  crtc_regs,
  output logic      [17:0]     start_addr,
  output logic      [17:0]     cursor_addr,
  output logic      [5:0]      cursor_start,
  output logic      [5:0]      cursor_end,
  output logic      [5:0]      preset_row,
  output logic      [5:0]      max_scan
);

  crtcl_regs_if #(.N(N)) rf ();

  crtcl_regfile #(.N(N)) crtcl_regfile_i (
    .clk  (clk),
    .nrst (nrst),
    .rf   (rf)
  );

  logic [7:0] crtc_idx_q;
  logic [7:0] crtc_idx_d;
  logic [7:0] gfx_idx_q;
  logic [7:0] gfx_idx_d;
  logic [7:0] lock_q;
  logic [7:0] lock_d;
  logic [7:0] misc_q;
  logic [7:0] misc_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  logic        color;
  logic [15:0] port_idx;
  logic [15:0] port_dat;
  logic        protect;
  logic        idx_in_range;
  logic [7:0]  crtc_rd;
  logic [7:0]  wmask;

  // i/o address of the crtc pair follows the colour select bit
  assign color    = misc_q[CRTCL_MISC_COLOR];
  assign port_idx = color ? CRTCL_PORT_IDX_COLOR : CRTCL_PORT_IDX_MONO;
  assign port_dat = color ? CRTCL_PORT_DAT_COLOR : CRTCL_PORT_DAT_MONO;
  assign protect  = rf.regs[CRTCL_IDX_VRE][CRTCL_VRE_PROTECT_BIT];
  assign idx_in_range = (crtc_idx_q < 8'(N));
  assign crtc_rd  = idx_in_range ? rf.regs[crtc_idx_q[4:0]] : CRTCL_RD_NONE;

  // writable bits of the selected crtc register
  function automatic logic [7:0] crtcl_wmask(
    input logic [4:0] idx,
    input logic [7:0] lc,
    input logic       prot
  );
    logic [7:0] m;
    m = 8'hFF;
    if (idx <= CRTCL_IDX_HLAST)
    begin
      if (lc[CRTCL_LC_HLOCK] || prot)
        m = 8'h00;  // [RULE2]
    end
    else if (idx == CRTCL_IDX_VTOTAL)
    begin
      if (lc[CRTCL_LC_VLOCK] || prot)
        m = 8'h00;  // [RULE4]
    end
    else if (idx == CRTCL_IDX_OVERFLOW)
    begin
      if (prot)
        m = m & ~CRTCL_OVF_PROT_BITS;  // [RULE1]
      if (!lc[CRTCL_LC_G1_PREVENT] && prot)
        m = m & ~CRTCL_OVF_G1_BITS;  // [RULE3]
      if (lc[CRTCL_LC_VLOCK] || prot)
        m = m & ~CRTCL_OVF_G2_BITS;  // [RULE4]
    end
    else if (idx == CRTCL_IDX_MAXSCAN)
    begin
      if (lc[CRTCL_LC_VLOCK])
        m = ~CRTCL_MAXSCAN_G3;  // [RULE5]
    end
    else if (idx == CRTCL_IDX_VRS || idx == CRTCL_IDX_VBS
             || idx == CRTCL_IDX_VBE)
    begin
      if (lc[CRTCL_LC_VLOCK])
        m = 8'h00;  // [RULE5]
    end
    else if (idx == CRTCL_IDX_VRE)
    begin
      if (lc[CRTCL_LC_VLOCK])
        m = ~CRTCL_VRE_G3;  // [RULE5]
    end
    else if (idx == CRTCL_IDX_MODE)
    begin
      if (lc[CRTCL_LC_HLOCK])
        m = ~CRTCL_MODE_G4;  // [RULE6]
    end
    return m;
  endfunction

  assign wmask = crtcl_wmask(crtc_idx_q[4:0], lock_q, protect);

  // crtc store write port
  always_comb
  begin
    rf.we    = io_wr && (io_addr == port_dat) && idx_in_range;  // [RULE8]
    rf.idx   = crtc_idx_q[4:0];
    rf.wdata = io_wdata;
    rf.wmask = wmask;  // [RULE12]
  end

  // host port state
  always_comb
  begin
    crtc_idx_d = crtc_idx_q;
    gfx_idx_d  = gfx_idx_q;
    lock_d     = lock_q;
    misc_d     = misc_q;
    rdata_d    = rdata_q;
    rvalid_d   = 1'b0;
    if (io_wr)
    begin
      if (io_addr == port_idx)
        crtc_idx_d = io_wdata;  // [RULE8]
      if (io_addr == CRTCL_PORT_GFX_IDX)
        gfx_idx_d = io_wdata;
      if (io_addr == CRTCL_PORT_GFX_DAT
          && gfx_idx_q == CRTCL_GFX_LOCK_CTRL)
        lock_d = io_wdata;  // [RULE7]
      if (io_addr == CRTCL_PORT_MISC_WR)
      begin
        misc_d = io_wdata;
        if (lock_q[CRTCL_LC_VPOL_LOCK])
          misc_d[CRTCL_MISC_VPOL] = misc_q[CRTCL_MISC_VPOL];  // [RULE13]
        if (lock_q[CRTCL_LC_HPOL_LOCK])
          misc_d[CRTCL_MISC_HPOL] = misc_q[CRTCL_MISC_HPOL];  // [RULE13]
      end
    end
    if (io_rd)
    begin
      rvalid_d = 1'b1;
      if (io_addr == port_idx)
        rdata_d = crtc_idx_q;
      else if (io_addr == port_dat)
        rdata_d = crtc_rd;  // [RULE12]
      else if (io_addr == CRTCL_PORT_GFX_IDX)
        rdata_d = gfx_idx_q;
      else if (io_addr == CRTCL_PORT_GFX_DAT
               && gfx_idx_q == CRTCL_GFX_LOCK_CTRL)
        rdata_d = lock_q;  // [RULE7]
      else if (io_addr == CRTCL_PORT_MISC_RD)
        rdata_d = misc_q;
      else
        rdata_d = CRTCL_RD_NONE;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crtc_idx_q <= CRTCL_RST_INDEX;
      gfx_idx_q  <= CRTCL_RST_INDEX;
      lock_q     <= CRTCL_RST_LOCK_CTRL;
      misc_q     <= CRTCL_RST_MISC;
      rdata_q    <= CRTCL_RD_NONE;
      rvalid_q   <= 1'b0;
    end
    else
    begin
      crtc_idx_q <= crtc_idx_d;
      gfx_idx_q  <= gfx_idx_d;
      lock_q     <= lock_d;
      misc_q     <= misc_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
    end
  end

  // values presented to the display timing logic
  function automatic logic [5:0] crtcl_scale(
    input logic [4:0] v,
    input logic       dbl
  );
    return dbl ? {v, 1'b0} : {1'b0, v};  // [RULE9]
  endfunction

  always_comb
  begin
    start_addr  = {lock_q[CRTCL_LC_ADDR9],             // [RULE11]
                   lock_q[CRTCL_LC_ADDR8],             // [RULE10]
                   rf.regs[CRTCL_IDX_SA_HI],
                   rf.regs[CRTCL_IDX_SA_LO]};
    cursor_addr = {lock_q[CRTCL_LC_ADDR9],             // [RULE11]
                   lock_q[CRTCL_LC_ADDR8],             // [RULE10]
                   rf.regs[CRTCL_IDX_CUR_HI],
                   rf.regs[CRTCL_IDX_CUR_LO]};
    cursor_start = crtcl_scale(rf.regs[CRTCL_IDX_CUR_START][4:0],
                               lock_q[CRTCL_LC_DOUBLE]);
    cursor_end   = crtcl_scale(rf.regs[CRTCL_IDX_CUR_END][4:0],
                               lock_q[CRTCL_LC_DOUBLE]);
    preset_row   = crtcl_scale(rf.regs[CRTCL_IDX_PRESET][4:0],
                               lock_q[CRTCL_LC_DOUBLE]);
    max_scan     = crtcl_scale(rf.regs[CRTCL_IDX_MAXSCAN][4:0],
                               lock_q[CRTCL_LC_DOUBLE]);
  end

  assign io_rdata  = rdata_q;
  assign io_rvalid = rvalid_q;
  assign lock_ctrl = lock_q;
  assign misc_out  = misc_q;
  assign crtc_regs = rf.regs;

endmodule // crtcl_lock

// File: verification/crtcl_lock_assertions.sv
// crtcl_lock_assertions: port checks of the crtc write lock
// assumes: bound into crtcl_lock, one clock
`timescale 1ns/100ps
module crtcl_lock_assertions
  import crtcl_pkg::*;
#(
  parameter int N = CRTCL_NREGS
)(
  input wire logic           clk,
  input wire logic           nrst,
  input wire logic           io_rd,
  input wire logic           io_rvalid,
  input wire logic [7:0]     lock_ctrl,
  input wire logic [7:0]     misc_out,
  input wire logic [8*N-1:0] crtc_regs,
  input wire logic [17:0]    start_addr,
  input wire logic [17:0]    cursor_addr,
  input wire logic [5:0]     cursor_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire prot = crtc_regs[143];
  prot_lock_a: assert property (prot |=> $stable(crtc_regs[55:0]))
    else $error("protect let a write into 0-6");
  hgrp_lock_a: assert property (lock_ctrl[5] |=> $stable(crtc_regs[47:0]))
    else $error("horizontal group changed");
  ovf_g1_a: assert property (!lock_ctrl[1] && prot |=>
    $stable({crtc_regs[62], crtc_regs[57]})) else $error("overflow 6,1");
  vgrp_lock_a: assert property (lock_ctrl[0] || prot |=>
    $stable(crtc_regs[63:48] & 16'hADFF)) else $error("vertical group");
  vgrp_ext_a: assert property (lock_ctrl[0] |=> $stable({crtc_regs[77],
    crtc_regs[139:128], crtc_regs[183:168]})) else $error("group 3");
  mode_lock_a: assert property (lock_ctrl[5] |=> $stable(crtc_regs[186]))
    else $error("mode bit 2 changed");
  read_ans_a: assert property (io_rd |=> io_rvalid)
    else $error("no read answer");
  dbl_scan_a: assert property (cursor_start == (lock_ctrl[2] ?
    {crtc_regs[84:80], 1'b0} : {1'b0, crtc_regs[84:80]})) else $error("dbl");
  addr_hi_a: assert property ({start_addr[17:16], cursor_addr[17:16]} ==
    {2{lock_ctrl[4:3]}}) else $error("address bits 9,8");
  vpol_lock_a: assert property (lock_ctrl[7] |=> $stable(misc_out[7]))
    else $error("vsync polarity changed");
  hpol_lock_a: assert property (lock_ctrl[6] |=> $stable(misc_out[6]))
    else $error("hsync polarity changed");
  cover property (prot ##1 io_rvalid);
  cover property (lock_ctrl[0] && lock_ctrl[5]);
  cover property (lock_ctrl[2] && cursor_start != 6'h00);
endmodule // crtcl_lock_assertions

bind crtcl_lock crtcl_lock_assertions #(.N(N)) crtcl_lock_assertions_i (
  .clk(clk), .nrst(nrst), .io_rd(io_rd), .io_rvalid(io_rvalid),
  .lock_ctrl(lock_ctrl), .misc_out(misc_out), .crtc_regs(crtc_regs),
  .start_addr(start_addr), .cursor_addr(cursor_addr),
  .cursor_start(cursor_start));

// File: verification/crtcl_host.sv
// crtcl_host: host processor on the indexed i/o port bus
// assumes: tasks called by the bench, one-cycle strobes
`timescale 1ns/100ps
module crtcl_host
  import crtcl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata
);
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = x;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~x;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] x,
                    output logic v);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    x = io_rdata;
    v = io_rvalid;
  endtask
  // index port first, then data port
  task automatic crtc_wr(input logic [4:0] i, input logic [7:0] x);
    wr(CRTCL_PORT_IDX_MONO, {3'h0, i});
    wr(CRTCL_PORT_DAT_MONO, x);
  endtask
endmodule // crtcl_host

// File: verification/crtcl_lock_tb.sv
// crtcl_lock_tb: self-checking bench of the crtc write lock
// assumes: crtcl_host drives the port bus
`timescale 1ns/100ps
module crtcl_lock_tb;
  import crtcl_pkg::*;
  logic                     clk, nrst, io_wr, io_rd, io_rvalid, v;
  logic [15:0]              io_addr;
  logic [7:0]               io_wdata, io_rdata, lock_ctrl, misc_out, d;
  logic [8*CRTCL_NREGS-1:0] crtc_regs;
  logic [17:0]              start_addr, cursor_addr;
  logic [5:0]               cursor_start, cursor_end, preset_row, max_scan;
  int                       fails, tests_run;
  localparam logic [4:0] GI [0:10] = '{5'h00, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h10, 5'h11, 5'h15, 5'h16, 5'h17};
  localparam logic [7:0] GE [0:10] = '{8'h00, 8'h00, 8'h00, 8'h52, 8'hFF,
    8'hDF, 8'h00, 8'hF0, 8'h00, 8'h00, 8'hFB};
  crtcl_lock crtcl_lock_i (.clk(clk), .nrst(nrst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .lock_ctrl(lock_ctrl), .misc_out(misc_out),
    .crtc_regs(crtc_regs), .start_addr(start_addr),
    .cursor_addr(cursor_addr), .cursor_start(cursor_start),
    .cursor_end(cursor_end), .preset_row(preset_row), .max_scan(max_scan));
  crtcl_host crtcl_host_i (.clk(clk), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rst;
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
  endtask
  task automatic lc_wr(input logic [7:0] x);
    crtcl_host_i.wr(CRTCL_PORT_GFX_IDX, CRTCL_GFX_LOCK_CTRL);
    crtcl_host_i.wr(CRTCL_PORT_GFX_DAT, x);
  endtask
  task automatic rd_chk(input logic [4:0] i, input logic [7:0] exp);
    crtcl_host_i.wr(CRTCL_PORT_IDX_MONO, {3'h0, i});
    crtcl_host_i.rd(CRTCL_PORT_DAT_MONO, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic t_lockreg;
    rst;
    chk(lock_ctrl, CRTCL_RST_LOCK_CTRL);
    lc_wr(8'h5A);
    crtcl_host_i.rd(CRTCL_PORT_GFX_DAT, d, v);
    chk(d, 8'h5A);
    chk({4'h0, start_addr[17:16], cursor_addr[17:16]}, 8'h0F);
    crtcl_host_i.crtc_wr(CRTCL_IDX_CUR_START, 8'h15);
    crtcl_host_i.crtc_wr(CRTCL_IDX_CUR_END, 8'h1F);
    crtcl_host_i.crtc_wr(CRTCL_IDX_PRESET, 8'h01);
    crtcl_host_i.crtc_wr(CRTCL_IDX_MAXSCAN, 8'h0F);
    crtcl_host_i.crtc_wr(CRTCL_IDX_SA_HI, 8'h12);
    crtcl_host_i.crtc_wr(CRTCL_IDX_CUR_LO, 8'h34);
    chk(start_addr[15:8], 8'h12);
    chk(cursor_addr[7:0], 8'h34);
    chk({2'h0, max_scan}, 8'h0F);
    lc_wr(8'h04);
    chk({2'h0, cursor_start}, 8'h2A);
    chk({2'h0, cursor_end}, 8'h3E);
    chk({2'h0, preset_row}, 8'h02);
    chk({2'h0, max_scan}, 8'h1E);
    crtcl_host_i.wr(CRTCL_PORT_GFX_IDX, 8'h0E);
    crtcl_host_i.rd(CRTCL_PORT_GFX_DAT, d, v);
    chk(d, CRTCL_RD_NONE);
  endtask
  task automatic t_protect;
    rst;
    crtcl_host_i.crtc_wr(CRTCL_IDX_VRE, 8'h80);
    crtcl_host_i.crtc_wr(5'h00, 8'hAA);
    crtcl_host_i.crtc_wr(CRTCL_IDX_OVERFLOW, 8'hFF);
    rd_chk(5'h00, 8'h00);
    rd_chk(CRTCL_IDX_OVERFLOW, 8'h00);
    lc_wr(8'h02);
    crtcl_host_i.crtc_wr(CRTCL_IDX_OVERFLOW, 8'hFF);
    rd_chk(CRTCL_IDX_OVERFLOW, CRTCL_OVF_G1_BITS);
    crtcl_host_i.crtc_wr(CRTCL_IDX_VRE, 8'h00);
    crtcl_host_i.crtc_wr(5'h00, 8'hAA);
    rd_chk(5'h00, 8'hAA);
  endtask
  task automatic t_groups;
    rst;
    lc_wr(8'h21);
    for (int k = 0; k < 11; k++)
    begin
      crtcl_host_i.crtc_wr(GI[k], 8'hFF);
      rd_chk(GI[k], GE[k]);
    end
  endtask
  task automatic t_misc;
    rst;
    crtcl_host_i.wr(CRTCL_PORT_MISC_WR, 8'hC0);
    lc_wr(8'hC0);
    crtcl_host_i.wr(CRTCL_PORT_MISC_WR, 8'h00);
    crtcl_host_i.rd(CRTCL_PORT_MISC_RD, d, v);
    chk(d, 8'hC0);
    lc_wr(8'h00);
    crtcl_host_i.wr(CRTCL_PORT_MISC_WR, 8'h00);
    chk(misc_out, 8'h00);
    crtcl_host_i.wr(CRTCL_PORT_MISC_WR, 8'h01);
    crtcl_host_i.wr(CRTCL_PORT_IDX_COLOR, {3'h0, CRTCL_IDX_SA_HI});
    crtcl_host_i.wr(CRTCL_PORT_DAT_COLOR, 8'h5C);
    chk(start_addr[15:8], 8'h5C);
    crtcl_host_i.rd(CRTCL_PORT_DAT_COLOR, d, v);
    chk(d, 8'h5C);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    fails = 0;
    tests_run = 0;
    nrst = 1'b0;
    t_lockreg;
    t_protect;
    t_groups;
    t_misc;
    tally_and_finish;
  end
  initial
  begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule // crtcl_lock_tb
